// ### rtl/fieldbus_status_and_program_control.sv
`timescale 1ns/1ps
module fieldbus_status_and_program_control
    import fbpc_pkg::*;
#(
    parameter logic [31:0] MASK_PRESET   = MASK_RST,
    parameter logic [31:0] ACTIVE_PRESET = ACTIVE_RST
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Object dictionary access
    input  wire logic        od_req,
    input  wire logic        od_wr,
    input  wire logic [15:0] od_index,
    input  wire logic [7:0]  od_sub,
    input  wire logic [31:0] od_wdata,
    output logic             od_ack,
    output logic [31:0]      od_rdata,
    output od_resp_t         od_resp,
    // Process data mapping
    input  wire logic        rpdo_ctrl_valid,
    input  wire logic [31:0] rpdo_ctrl_data,
    output logic [31:0]      tpdo_prog_state,
    output logic [31:0]      tpdo_fault_code,
    // Fieldbus switching result from the control object
    input  wire logic        fb_active_upd,
    input  wire logic [31:0] fb_active_val,
    // User program engine
    input  wire logic        prog_reload_done,
    input  wire logic        prog_clear_done,
    input  wire logic        prog_fault,
    input  wire logic [31:0] prog_fault_code,
    output logic             prog_reload_req,
    output logic             prog_clear_req,
    output logic             prog_run_en
);

    // Presets must fit the used bit map, otherwise readback would show spare bits
    if ((MASK_PRESET & ~IFACE_USED_MASK) != 32'h0000_0000) begin : g_chk_mask
        $error("MASK_PRESET sets unused bits");
    end
    if ((ACTIVE_PRESET & ~IFACE_USED_MASK) != 32'h0000_0000) begin : g_chk_active
        $error("ACTIVE_PRESET sets unused bits");
    end

    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] active_ff;
    logic [31:0] nxt_active;
    logic [31:0] mask_ff;
    logic [31:0] nxt_mask;
    logic        od_ack_ff;
    logic        nxt_od_ack;
    logic [31:0] od_rdata_ff;
    logic [31:0] nxt_od_rdata;
    od_resp_t    od_resp_ff;
    od_resp_t    nxt_od_resp;
    logic [31:0] state_ff;
    logic [31:0] nxt_state;
    logic [31:0] fcode_ff;
    logic [31:0] nxt_fcode;

    logic        eng_running;
    logic        eng_fault_flag;
    logic [31:0] eng_fault_code;
    logic [31:0] live_state;
    logic        hit;
    logic        writable;
    logic [31:0] rd_word;

    // Program sequencing

    program_launcher u_launcher (
        .clk               (clk),
        .arst_n            (arst_n),
        .switch_on         (ctrl_ff[CTRL_SWITCH_BIT]),
        .reload_done       (prog_reload_done),
        .clear_done        (prog_clear_done),
        .engine_fault      (prog_fault),
        .engine_fault_code (prog_fault_code),
        .reload_req        (prog_reload_req),
        .clear_req         (prog_clear_req),
        .run_en            (prog_run_en),
        .running           (eng_running),
        .fault_flag        (eng_fault_flag),
        .fault_code        (eng_fault_code)
    );

    // Status word assembly

    always_comb begin
        live_state                  = STATE_RST;
        live_state[STATE_RUN_BIT]   = eng_running;
        live_state[STATE_SPARE_BIT] = 1'b0;
        live_state[STATE_FAULT_BIT] = eng_fault_flag;
    end

    // Object decode

    always_comb begin
        hit      = 1'b0;
        writable = 1'b0;
        rd_word  = 32'h0000_0000;
        unique case (od_index)
            OBJ_FB_STATUS: begin
                if (od_sub == SUB_HIGHEST) begin
                    hit     = 1'b1;
                    rd_word = {24'h00_0000, HIGHEST_SUB_VAL};
                end else if (od_sub == SUB_MASK) begin
                    hit     = 1'b1;
                    rd_word = mask_ff;
                end else if (od_sub == SUB_ACTIVE) begin
                    hit     = 1'b1;
                    rd_word = active_ff;
                end
            end
            OBJ_PROG_CTRL: begin
                if (od_sub == SUB_HIGHEST) begin
                    hit      = 1'b1;
                    writable = 1'b1;
                    rd_word  = ctrl_ff;
                end
            end
            OBJ_PROG_STATE: begin
                if (od_sub == SUB_HIGHEST) begin
                    hit     = 1'b1;
                    rd_word = state_ff;
                end
            end
            OBJ_PROG_FAULT: begin
                if (od_sub == SUB_HIGHEST) begin
                    hit     = 1'b1;
                    rd_word = fcode_ff;
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Access answer

    always_comb begin
        nxt_od_ack   = od_req;
        nxt_od_rdata = od_rdata_ff;
        nxt_od_resp  = od_resp_ff;
        if (od_req) begin
            nxt_od_rdata = 32'h0000_0000;
            if (!hit) begin
                nxt_od_resp = OD_NO_OBJECT;
            end else if (od_wr && !writable) begin
                nxt_od_resp = OD_READ_ONLY;
            end else begin
                nxt_od_resp = OD_OK;
                if (!od_wr) begin
                    nxt_od_rdata = rd_word;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            od_ack_ff   <= 1'b0;
            od_rdata_ff <= 32'h0000_0000;
            od_resp_ff  <= OD_OK;
        end else begin
            od_ack_ff   <= nxt_od_ack;
            od_rdata_ff <= nxt_od_rdata;
            od_resp_ff  <= nxt_od_resp;
        end
    end

    // Control and status storage

    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_mask   = mask_ff;
        nxt_active = active_ff;
        nxt_state  = live_state;
        nxt_fcode  = eng_fault_code;
        // Process data first, so a same-cycle dictionary write lands last
        if (rpdo_ctrl_valid) begin
            nxt_ctrl = rpdo_ctrl_data;
        end
        if (od_req && od_wr && hit && writable) begin
            nxt_ctrl = od_wdata;
        end
        // Only masked interfaces may change; fixed ones keep their state
        if (fb_active_upd) begin
            nxt_active = ((fb_active_val & mask_ff) | (active_ff & ~mask_ff))
                         & IFACE_USED_MASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff   <= CTRL_RST;
            mask_ff   <= MASK_PRESET;
            active_ff <= ACTIVE_PRESET;
            state_ff  <= STATE_RST;
            fcode_ff  <= FAULT_RST;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            mask_ff   <= nxt_mask;
            active_ff <= nxt_active;
            state_ff  <= nxt_state;
            fcode_ff  <= nxt_fcode;
        end
    end

    // Outputs

    assign od_ack          = od_ack_ff;
    assign od_rdata        = od_rdata_ff;
    assign od_resp         = od_resp_ff;
    assign tpdo_prog_state = state_ff;
    assign tpdo_fault_code = fcode_ff;

endmodule

// ### rtl/fbpc_pkg.sv
package fbpc_pkg;

    // Object dictionary indices and sub-indices
    localparam logic [15:0] OBJ_FB_STATUS  = 16'h2103;
    localparam logic [15:0] OBJ_PROG_CTRL  = 16'h2300;
    localparam logic [15:0] OBJ_PROG_STATE = 16'h2301;
    localparam logic [15:0] OBJ_PROG_FAULT = 16'h2302;
    localparam logic [7:0]  SUB_HIGHEST    = 8'h00;
    localparam logic [7:0]  SUB_MASK       = 8'h01;
    localparam logic [7:0]  SUB_ACTIVE     = 8'h02;

    // Preset values
    localparam logic [7:0]  HIGHEST_SUB_VAL = 8'h02;
    localparam logic [31:0] MASK_RST        = 32'h0000_0008;
    localparam logic [31:0] ACTIVE_RST      = 32'h0000_0018;
    localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
    localparam logic [31:0] STATE_RST       = 32'h0000_0000;
    localparam logic [31:0] FAULT_RST       = 32'h0000_0000;

    // Interface and protocol bit map
    localparam int USB_BIT                    = 0;
    localparam int RS485_BIT                  = 1;
    localparam int RS232_BIT                  = 2;
    localparam int CAN_BIT                    = 3;
    localparam int WIRED_LAN_IFACE_BIT        = 4;
    localparam int REALTIME_FIELDBUS_BIT      = 5;
    localparam int SPI_BIT                    = 6;
    localparam int SERIAL_MODBUS_BIT          = 16;
    localparam int TCP_MODBUS_BIT             = 17;
    localparam int INDUSTRIAL_IP_PROTOCOL_BIT = 18;
    localparam logic [31:0] IFACE_USED_MASK   = 32'h0007_007F;

    // Program control and state fields
    localparam int CTRL_SWITCH_BIT  = 0;
    localparam int STATE_RUN_BIT    = 0;
    localparam int STATE_SPARE_BIT  = 1;
    localparam int STATE_FAULT_BIT  = 2;

    // Fault codes
    localparam logic [31:0] FAULT_NONE     = 32'h0000_0000;
    localparam logic [31:0] FAULT_BAD_FILE = 32'h0000_0100;

    typedef enum logic [1:0] {
        OD_OK        = 2'b00,
        OD_NO_OBJECT = 2'b01,
        OD_READ_ONLY = 2'b10
    } od_resp_t;

    typedef enum logic [2:0] {
        PS_IDLE   = 3'b000,
        PS_RELOAD = 3'b001,
        PS_CLEAR  = 3'b011,
        PS_RUN    = 3'b010,
        PS_FAULT  = 3'b110
    } prog_state_t;

endpackage

// ### rtl/program_launcher.sv
`timescale 1ns/1ps
module program_launcher
    import fbpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        switch_on,
    input  wire logic        reload_done,
    input  wire logic        clear_done,
    input  wire logic        engine_fault,
    input  wire logic [31:0] engine_fault_code,
    output logic             reload_req,
    output logic             clear_req,
    output logic             run_en,
    output logic             running,
    output logic             fault_flag,
    output logic [31:0]      fault_code
);

    prog_state_t state_ff;
    prog_state_t nxt_state;
    logic        switch_prev_ff;
    logic        nxt_switch_prev;
    logic        fault_flag_ff;
    logic        nxt_fault_flag;
    logic [31:0] fault_code_ff;
    logic [31:0] nxt_fault_code;
    logic        rise;

    always_comb begin
        rise            = switch_on & ~switch_prev_ff;
        nxt_switch_prev = switch_on;
        nxt_state       = state_ff;
        nxt_fault_flag  = fault_flag_ff;
        nxt_fault_code  = fault_code_ff;
        unique case (state_ff)
            PS_IDLE, PS_FAULT: begin
                if (rise) begin
                    nxt_state      = PS_RELOAD;
                    nxt_fault_flag = 1'b0;
                    nxt_fault_code = FAULT_NONE;
                end else if (!switch_on) begin
                    nxt_state = PS_IDLE;
                end
            end
            PS_RELOAD: begin
                if (reload_done) begin
                    nxt_state = PS_CLEAR;
                end
            end
            PS_CLEAR: begin
                if (clear_done) begin
                    nxt_state = PS_RUN;
                end
            end
            PS_RUN: begin
            end
            default: begin
                nxt_state = PS_IDLE;
            end
        endcase
        // Fault ends the program; outside idle and fault it outranks every other transition
        if (engine_fault && (state_ff != PS_IDLE) && (state_ff != PS_FAULT)) begin
            nxt_state      = PS_FAULT;
            nxt_fault_flag = 1'b1;
            nxt_fault_code = engine_fault_code;
        end else if (!switch_on && (state_ff != PS_FAULT)) begin
            nxt_state = PS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff       <= PS_IDLE;
            switch_prev_ff <= 1'b0;
            fault_flag_ff  <= 1'b0;
            fault_code_ff  <= FAULT_RST;
            reload_req     <= 1'b0;
            clear_req      <= 1'b0;
            run_en         <= 1'b0;
            running        <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            switch_prev_ff <= nxt_switch_prev;
            fault_flag_ff  <= nxt_fault_flag;
            fault_code_ff  <= nxt_fault_code;
            reload_req     <= (nxt_state == PS_RELOAD);
            clear_req      <= (nxt_state == PS_CLEAR);
            run_en         <= (nxt_state == PS_RUN);
            running        <= (nxt_state == PS_RUN);
        end
    end

    assign fault_flag = fault_flag_ff;
    assign fault_code = fault_code_ff;

endmodule

// ### dv/fbpc_chk.sv
`timescale 1ns/1ps
module fbpc_chk
    import fbpc_pkg::*;
#(
    parameter logic [31:0] MASK_PRESET = MASK_RST
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        od_req,
    input wire logic        od_wr,
    input wire logic [15:0] od_index,
    input wire logic [7:0]  od_sub,
    input wire logic        od_ack,
    input wire logic [31:0] od_rdata,
    input wire od_resp_t    od_resp,
    input wire logic [31:0] tpdo_prog_state,
    input wire logic        prog_fault,
    input wire logic        prog_reload_req,
    input wire logic        prog_clear_req,
    input wire logic        prog_run_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd(sb);
        od_req && !od_wr && od_index == OBJ_FB_STATUS && od_sub == sb;
    endsequence
    sequence s_fault_hit;
        prog_fault && prog_run_en;
    endsequence
    a_ack_follows_req: assert property (od_req |=> od_ack)
        else $error("ack missing after request");
    a_no_stray_ack: assert property (!od_req |=> !od_ack)
        else $error("ack without request");
    a_highest_read: assert property (s_rd(SUB_HIGHEST) |=> od_rdata == 32'h0000_0002)
        else $error("highest sub entry wrong");
    a_mask_read: assert property (s_rd(SUB_MASK) |=> od_rdata == MASK_PRESET)
        else $error("disable mask wrong");
    a_ro_refused: assert property (
        od_req && od_wr && od_index == OBJ_PROG_STATE && od_sub == SUB_HIGHEST
        |=> od_resp == OD_READ_ONLY)
        else $error("read-only write accepted");
    a_clear_after_reload: assert property ($rose(prog_clear_req) |-> $past(prog_reload_req))
        else $error("clear without reload");
    a_run_after_clear: assert property ($rose(prog_run_en) |-> $past(prog_clear_req))
        else $error("run without clear");
    a_state_follows_run: assert property (
        ##1 tpdo_prog_state[STATE_RUN_BIT] == $past(prog_run_en))
        else $error("active flag does not follow run");
    a_fault_stop: assert property (
        s_fault_hit |=> !prog_run_en ##[0:1] tpdo_prog_state[STATE_FAULT_BIT])
        else $error("fault not flagged");
    a_spare_zero: assert property (!tpdo_prog_state[STATE_SPARE_BIT])
        else $error("spare status bit set");
endmodule

// ### dv/prog_engine_model.sv
`timescale 1ns/1ps
module prog_engine_model #(
    parameter int DLY = 5
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic reload_req,
    input  wire logic clear_req,
    output logic      reload_done,
    output logic      clear_done
);
    logic [7:0] cnt_ff;
    logic       done;
    // Done only inside a phase, so a stale done cannot skip a step
    assign done = (reload_req || clear_req) && cnt_ff == DLY[7:0];
    assign reload_done = reload_req && done;
    assign clear_done = clear_req && done;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) cnt_ff <= 8'h00;
        else cnt_ff <= (done || !(reload_req || clear_req)) ? 8'h00 : cnt_ff + 8'h01;
    end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
    import fbpc_pkg::*;
    logic clk = 0, arst_n = 0, od_req = 0, od_wr = 0, od_ack, rv = 0, fu = 0, pf = 0;
    logic [15:0] od_index = 16'h0000;
    logic [7:0]  od_sub = 8'h00;
    logic [31:0] od_wdata = 32'h0000_0000, od_rdata, rd, rdat = 32'h0000_0000;
    logic [31:0] fv = 32'h0000_0000, pfc = 32'h0000_0000, st, fc;
    logic        rl, cl, re, rld, cld;
    od_resp_t    od_resp, rs;
    int          errors = 0, total_checks = 0;
    always #5 clk = ~clk;
    fieldbus_status_and_program_control i_fieldbus_status_and_program_control (
        .clk(clk), .arst_n(arst_n), .od_req(od_req), .od_wr(od_wr), .od_index(od_index),
        .od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack), .od_rdata(od_rdata),
        .od_resp(od_resp), .rpdo_ctrl_valid(rv), .rpdo_ctrl_data(rdat),
        .tpdo_prog_state(st), .tpdo_fault_code(fc), .fb_active_upd(fu), .fb_active_val(fv),
        .prog_reload_done(rld), .prog_clear_done(cld), .prog_fault(pf),
        .prog_fault_code(pfc), .prog_reload_req(rl), .prog_clear_req(cl), .prog_run_en(re));
    prog_engine_model i_prog_engine_model (.clk(clk), .arst_n(arst_n), .reload_req(rl),
        .clear_req(cl), .reload_done(rld), .clear_done(cld));
    task chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task od(logic w, logic [15:0] i, logic [7:0] s, logic [31:0] d);
        @(negedge clk);
        {od_req, od_wr, od_index, od_sub, od_wdata} = {1'b1, w, i, s, d};
        @(negedge clk);
        od_req = 0;
        chk("ack", {31'h0, od_ack}, 32'h1);
        rd = od_rdata;
        rs = od_resp;
    endtask
    task rdchk(logic [15:0] i, logic [7:0] s, logic [31:0] e);
        od(0, i, s, 0);
        chk("rdata", rd, e);
        chk("resp", {30'h0, rs}, {30'h0, OD_OK});
    endtask
    task wait_run(logic v);
        // Master waits a bounded span for start-up, far above the engine model's delay
        for (int k = 0; k < 300 && re !== v; k++) @(negedge clk);
        chk("run_en", {31'h0, re}, {31'h0, v});
    endtask
    task t_presets;
        rdchk(OBJ_FB_STATUS, SUB_HIGHEST, 32'h0000_0002);
        rdchk(OBJ_FB_STATUS, SUB_MASK, 32'h0000_0008);
        rdchk(OBJ_FB_STATUS, SUB_ACTIVE, 32'h0000_0018);
        rdchk(OBJ_PROG_CTRL, 8'h00, 32'h0000_0000);
        rdchk(OBJ_PROG_STATE, 8'h00, 32'h0000_0000);
        rdchk(OBJ_PROG_FAULT, 8'h00, 32'h0000_0000);
    endtask
    task t_refuse;
        od(1, OBJ_FB_STATUS, SUB_MASK, 32'hFFFF_FFFF);
        chk("ro mask", {30'h0, rs}, {30'h0, OD_READ_ONLY});
        od(1, OBJ_PROG_STATE, 8'h00, 32'h0000_0001);
        chk("ro state", {30'h0, rs}, {30'h0, OD_READ_ONLY});
        od(1, OBJ_PROG_FAULT, 8'h00, 32'h0000_0001);
        chk("ro fault", {30'h0, rs}, {30'h0, OD_READ_ONLY});
        od(0, 16'h2304, 8'h00, 0);
        chk("no object", {30'h0, rs}, {30'h0, OD_NO_OBJECT});
        rdchk(OBJ_FB_STATUS, SUB_MASK, 32'h0000_0008);
        rdchk(OBJ_PROG_STATE, 8'h00, 32'h0000_0000);
    endtask
    task t_active;
        @(negedge clk);
        {fu, fv} = {1'b1, 32'h0000_0000};
        @(negedge clk);
        fu = 0;
        rdchk(OBJ_FB_STATUS, SUB_ACTIVE, 32'h0000_0010);
        @(negedge clk);
        {fu, fv} = {1'b1, 32'hFFFF_FFFF};
        @(negedge clk);
        fu = 0;
        rdchk(OBJ_FB_STATUS, SUB_ACTIVE, 32'h0000_0018);
    endtask
    task t_launch;
        od(1, OBJ_PROG_CTRL, 8'h00, 32'h0000_0001);
        @(negedge clk);
        chk("reload first", {rl, cl, re}, 32'h4);
        wait_run(1);
        @(negedge clk);
        rdchk(OBJ_PROG_STATE, 8'h00, 32'h0000_0001);
        rdchk(OBJ_PROG_CTRL, 8'h00, 32'h0000_0001);
        od(1, OBJ_PROG_CTRL, 8'h00, 32'h0000_0000);
        wait_run(0);
        @(negedge clk);
        chk("stopped", st, 32'h0000_0000);
    endtask
    task t_fault;
        @(negedge clk);
        {rv, rdat} = {1'b1, 32'h0000_0001};
        @(negedge clk);
        rv = 0;
        wait_run(1);
        {pf, pfc} = {1'b1, FAULT_BAD_FILE};
        @(negedge clk);
        pf = 0;
        repeat (2) @(negedge clk);
        chk("fault state", st, 32'h0000_0004);
        chk("fault code", fc, 32'h0000_0100);
        rdchk(OBJ_PROG_FAULT, 8'h00, 32'h0000_0100);
        od(1, OBJ_PROG_CTRL, 8'h00, 32'h0000_0000);
        od(1, OBJ_PROG_CTRL, 8'h00, 32'h0000_0001);
        wait_run(1);
        @(negedge clk);
        chk("relaunch state", st, 32'h0000_0001);
        chk("code cleared", fc, FAULT_NONE);
    endtask
    task close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        close_out;
    end
    initial begin
        repeat (8) @(negedge clk);
        arst_n = 1;
        t_presets;
        t_refuse;
        t_active;
        t_launch;
        t_fault;
        close_out;
    end
endmodule
bind fieldbus_status_and_program_control fbpc_chk #(.MASK_PRESET(MASK_PRESET)) i_fbpc_chk (
    .clk(clk), .arst_n(arst_n), .od_req(od_req), .od_wr(od_wr), .od_index(od_index),
    .od_sub(od_sub), .od_ack(od_ack), .od_rdata(od_rdata), .od_resp(od_resp),
    .tpdo_prog_state(tpdo_prog_state), .prog_fault(prog_fault),
    .prog_reload_req(prog_reload_req), .prog_clear_req(prog_clear_req),
    .prog_run_en(prog_run_en));
